// ==== pkg/strain_seq_pkg.sv ====
// shared constants, types and mode tables for both ends of the strain frame sequencer
package strain_seq_pkg;
  // ==========================================================
  // timing
  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam real         FRAME_TICK_MS   = 6.4;
  localparam int unsigned FRAME_TICK_CYC  = int'(FRAME_TICK_MS * real'(CLK_HZ) / 1000.0);
  localparam int unsigned VSTABLE_S       = 5;
  localparam int unsigned VSTABLE_CYC     = VSTABLE_S * CLK_HZ;
  localparam int unsigned CYC_UNIT_US     = 2;
  localparam int unsigned CYC_UNIT_CYC    = CYC_UNIT_US * (CLK_HZ / 1_000_000);
  localparam int unsigned BRIEF_WAKE_CYC  = 16;

  // ==========================================================
  // measurement
  localparam int unsigned RES_W           = 32;
  localparam int unsigned CONV_PER_BRIDGE = 2;
  localparam int unsigned OFS_SAMPLES     = 10;
  // 1.5 kg at 0.1 kg per count
  localparam int unsigned LOAD_JUMP_CNT   = 15;
  localparam logic [1:0]  COMP_MEAS_ONLY  = 2'h1;
  localparam logic [2:0]  OSC_OFF         = 3'h0;

  // ==========================================================
  // wake causes and processor registers
  localparam int unsigned CAUSE_W         = 2;
  localparam int unsigned CAUSE_MEAS      = 0;
  localparam int unsigned CAUSE_TIMER     = 1;
  localparam logic [7:0]  A_CTRL          = 8'h00;
  localparam logic [7:0]  A_STATUS        = 8'h04;
  localparam logic [7:0]  A_WEIGHT        = 8'h08;
  localparam logic [7:0]  A_OFFSET        = 8'h0C;
  localparam logic [7:0]  A_IRQ_STAT      = 8'h10;
  localparam logic [7:0]  A_IRQ_MASK      = 8'h14;
  localparam int unsigned CTRL_RUN        = 0;
  localparam int unsigned IRQ_W           = 3;
  localparam int unsigned IRQ_FRAME       = 0;
  localparam int unsigned IRQ_MODE        = 1;
  localparam int unsigned IRQ_JUMP        = 2;
  localparam int unsigned HTRANS_ACT_BIT  = 1;
  localparam logic        HRESP_OKAY      = 1'b0;

  typedef enum logic [1:0] {MODE_PWRUP, MODE_MEAS, MODE_SCAN} mode_t;

  typedef struct packed {
    logic [7:0] frame_cnt;
    logic [9:0] avrate;
    logic [7:0] cycle_period_setting;
    logic [1:0] bridge_code;
    logic [1:0] dummy_measure_count;
    logic       converter_sleep_ctrl;
    logic       display_standby_ctrl;
    logic       gain_temp_correction_en;
    logic [1:0] comparator_power_ctrl;
    logic [2:0] osc_settle_delay_sel;
  } cfg_t;

  // frame 100/100/30, cycle period 53/77/30, averaging 2
  localparam cfg_t CFG_PWRUP = '{8'h64, 10'h002, 8'h35, 2'h0, 2'h0, 1'b1, 1'b1, 1'b0, 2'h1, 3'h0};
  localparam cfg_t CFG_MEAS  = '{8'h64, 10'h002, 8'h4D, 2'h3, 2'h1, 1'b0, 1'b0, 1'b1, 2'h1, 3'h2};
  localparam cfg_t CFG_SCAN  = '{8'h1E, 10'h002, 8'h1E, 2'h0, 2'h1, 1'b0, 1'b1, 1'b0, 2'h1, 3'h2};

  function automatic cfg_t mode_cfg(input mode_t m);
    case (m)
      MODE_MEAS: mode_cfg = CFG_MEAS;
      MODE_SCAN: mode_cfg = CFG_SCAN;
      default:   mode_cfg = CFG_PWRUP;
    endcase
  endfunction
endpackage

// ==== pkg/strain_link_if.sv ====
// link between the converter sequencer and the processor-side mode controller
`timescale 1ns/100ps
interface strain_link_if;
  import strain_seq_pkg::*;
  cfg_t               cfg;
  logic               cfg_load;
  logic               prog_done;
  logic [RES_W-1:0]   disp_value;
  logic               disp_load;
  logic               brief_wake;
  logic               frame_wake;
  logic [CAUSE_W-1:0] wake_cause;
  logic [RES_W-1:0]   frame_result;

  modport conv (
    input  cfg, cfg_load, prog_done, disp_value, disp_load,
    output brief_wake, frame_wake, wake_cause, frame_result
  );
  modport proc (
    output cfg, cfg_load, prog_done, disp_value, disp_load,
    input  brief_wake, frame_wake, wake_cause, frame_result
  );
endinterface

// ==== design/strain_frame_sequencer.sv ====
// converter frame sequencer: frame timer, discharge conversions and processor wake-ups
//
// What this block does
// - frame timer bounds one complete measurement frame
// - frame setting counts in 6.4 ms steps
// - two conversions per connected half-bridge
// - averaging one, four bridges: eight conversions
// - brief processor wake after each conversion
// - new frame only after processor finishes
// - wake cause flags shown to processor
// - controller keeps its state across wake-ups
// - power-up: display, comparator, oscillator off
// - sleep control one stops all conversions
// - measuring: averaging two, 1.5 Hz, displayed
// - scan: averaging two, 5.2 Hz, display off
// - measuring config after five stable seconds
// - offset: average ten unloaded results, subtract
// - scan offset acquired before scanning starts
// - scan load jump returns to measuring
// - load change aborts offset, go measuring
// - cycle period 53, 77, 30 by mode
`timescale 1ns/100ps
module strain_frame_sequencer #(
  parameter int unsigned FRAME_TICK = strain_seq_pkg::FRAME_TICK_CYC,
  parameter int unsigned CYC_UNIT   = strain_seq_pkg::CYC_UNIT_CYC,
  parameter int unsigned BRIEF_CYC  = strain_seq_pkg::BRIEF_WAKE_CYC
) (
  input  wire logic                        hclk,
  input  wire logic                        hresetn,
  strain_link_if.conv                      link,
  input  wire logic [strain_seq_pkg::RES_W-1:0] disch_time,
  output logic                             conv_active,
  output logic                             comparator_on,
  output logic                             osc_on,
  output logic                             display_on,
  output logic                             gain_temp_en,
  output logic                             cpu_awake,
  output logic [strain_seq_pkg::RES_W-1:0] display_data
);
  import strain_seq_pkg::*;

  // ==========================================================
  // helpers
  function automatic logic [15:0] conv_total(input cfg_t c);
    conv_total = 16'(c.dummy_measure_count)
               + 16'(CONV_PER_BRIDGE * (32'(c.bridge_code) + 32'd1) * 32'(c.avrate));
  endfunction

  function automatic logic [31:0] conv_len(input cfg_t c);
    conv_len = 32'(32'(c.cycle_period_setting) * CYC_UNIT);
  endfunction

  function automatic logic [31:0] frame_len(input cfg_t c);
    frame_len = 32'(32'(c.frame_cnt) * FRAME_TICK);
  endfunction

  // ==========================================================
  // state
  typedef enum logic [2:0] {S_START, S_CONV, S_BRIEF, S_END, S_WAIT, S_SLEEP} seq_t;

  seq_t               state;
  seq_t               next_state;
  cfg_t               act;
  cfg_t               next_act;
  cfg_t               pend;
  cfg_t               next_pend;
  logic               pend_vld;
  logic               next_pend_vld;
  logic [31:0]        timer;
  logic [31:0]        next_timer;
  logic [31:0]        cnt;
  logic [31:0]        next_cnt;
  logic [15:0]        idx;
  logic [15:0]        next_idx;
  logic [15:0]        total;
  logic [15:0]        next_total;
  logic [RES_W-1:0]   sum;
  logic [RES_W-1:0]   next_sum;
  logic               wake;
  logic               next_wake;
  logic [CAUSE_W-1:0] cause;
  logic [CAUSE_W-1:0] next_cause;
  logic [RES_W-1:0]   result;
  logic [RES_W-1:0]   next_result;
  logic [RES_W-1:0]   disp;
  logic [RES_W-1:0]   next_disp;
  cfg_t               eff;

  always_comb begin
    eff           = pend_vld ? pend : act;
    next_state    = state;
    next_act      = act;
    next_pend     = pend;
    next_pend_vld = pend_vld;
    next_timer    = (timer != 32'h0000_0000) ? timer - 32'h0000_0001 : timer;
    next_cnt      = (cnt != 32'h0000_0000) ? cnt - 32'h0000_0001 : cnt;
    next_idx      = idx;
    next_total    = total;
    next_sum      = sum;
    next_wake     = wake;
    next_cause    = cause;
    next_result   = result;
    next_disp     = disp;
    // held back until the next frame start so a frame never mixes settings
    if (link.cfg_load) begin
      next_pend     = link.cfg;
      next_pend_vld = 1'b1;
    end
    if (link.disp_load && !act.display_standby_ctrl) begin
      next_disp = link.disp_value;
    end
    case (state)
      S_START: begin
        next_act   = eff;
        next_timer = frame_len(eff);
        next_idx   = 16'h0000;
        next_sum   = '0;
        next_total = conv_total(eff);
        next_cnt   = conv_len(eff);
        if (!link.cfg_load) begin
          next_pend_vld = 1'b0;
        end
        if (eff.converter_sleep_ctrl) begin
          next_state = S_SLEEP;
        end else if (conv_total(eff) == 16'h0000) begin
          next_state = S_WAIT;
        end else begin
          next_state = S_CONV;
        end
      end
      S_CONV: begin
        if (cnt <= 32'h0000_0001) begin
          // dummy conversions settle the bridge but never reach the result
          if (idx >= 16'(act.dummy_measure_count)) begin
            next_sum = sum + disch_time;
          end
          next_idx   = idx + 16'h0001;
          next_cnt   = 32'(BRIEF_CYC);
          next_state = S_BRIEF;
        end
      end
      S_BRIEF: begin
        if (cnt <= 32'h0000_0001) begin
          if (idx >= total) begin
            next_wake   = 1'b1;
            next_cause  = CAUSE_W'(1) << CAUSE_MEAS;
            next_result = sum;
            next_state  = S_END;
          end else begin
            next_cnt   = conv_len(act);
            next_state = S_CONV;
          end
        end
      end
      S_SLEEP: begin
        // no conversion runs; the timer still wakes the processor each frame
        if (timer == 32'h0000_0000) begin
          next_wake  = 1'b1;
          next_cause = CAUSE_W'(1) << CAUSE_TIMER;
          next_state = S_END;
        end
      end
      S_END: begin
        if (link.prog_done) begin
          next_wake  = 1'b0;
          next_state = S_WAIT;
        end
      end
      S_WAIT: begin
        if (timer == 32'h0000_0000) begin
          next_state = S_START;
        end
      end
      default: begin
        next_state = S_START;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state    <= S_START;
      act      <= CFG_PWRUP;
      pend     <= CFG_PWRUP;
      pend_vld <= 1'b0;
      timer    <= 32'h0000_0000;
      cnt      <= 32'h0000_0000;
      idx      <= 16'h0000;
      total    <= 16'h0000;
      sum      <= '0;
      wake     <= 1'b0;
      cause    <= '0;
      result   <= '0;
      disp     <= '0;
    end else begin
      state    <= next_state;
      act      <= next_act;
      pend     <= next_pend;
      pend_vld <= next_pend_vld;
      timer    <= next_timer;
      cnt      <= next_cnt;
      idx      <= next_idx;
      total    <= next_total;
      sum      <= next_sum;
      wake     <= next_wake;
      cause    <= next_cause;
      result   <= next_result;
      disp     <= next_disp;
    end
  end

  // ==========================================================
  // outputs
  assign conv_active       = (state == S_CONV);
  // the comparator only draws current while a discharge is timed
  assign comparator_on     = conv_active && (act.comparator_power_ctrl == COMP_MEAS_ONLY);
  assign osc_on            = conv_active && (act.osc_settle_delay_sel != OSC_OFF);
  assign display_on        = !act.display_standby_ctrl;
  assign gain_temp_en      = act.gain_temp_correction_en && !act.converter_sleep_ctrl;
  assign cpu_awake         = (state == S_BRIEF) || wake;
  assign display_data      = disp;
  assign link.brief_wake   = (state == S_BRIEF);
  assign link.frame_wake   = wake;
  assign link.wake_cause   = cause;
  assign link.frame_result = result;
endmodule

// ==== design/strain_mode_controller.sv ====
// processor-side mode controller: power-up, offsets, measuring and scan, with an AHB-Lite register slave
`timescale 1ns/100ps
module strain_mode_controller #(
  parameter int unsigned VSTABLE = strain_seq_pkg::VSTABLE_CYC,
  parameter int unsigned JUMP    = strain_seq_pkg::LOAD_JUMP_CNT
) (
  input  wire logic                             hclk,
  input  wire logic                             hresetn,
  strain_link_if.proc                           link,
  input  wire logic                             supply_ok,
  input  wire logic                             hsel,
  input  wire logic [31:0]                      haddr,
  input  wire logic [1:0]                       htrans,
  input  wire logic                             hwrite,
  input  wire logic [2:0]                       hsize,
  input  wire logic [31:0]                      hwdata,
  input  wire logic                             hready,
  output logic [31:0]                           hrdata,
  output logic                                  hreadyout,
  output logic                                  hresp,
  output logic                                  irq,
  output logic [strain_seq_pkg::RES_W-1:0]      weight
);
  import strain_seq_pkg::*;

  function automatic logic jumped(input logic [RES_W-1:0] a, input logic [RES_W-1:0] b);
    jumped = ((a > b) ? a - b : b - a) > RES_W'(JUMP);
  endfunction

  // ==========================================================
  // supply monitor and mode state machine
  typedef enum logic [2:0] {C_PWRUP, C_OFS_MEAS, C_MEAS, C_OFS_SCAN, C_SCAN} ctl_t;

  logic              sup_s1;
  logic              sup_s2;
  logic [31:0]       vcnt;
  logic [31:0]       next_vcnt;
  ctl_t              st;
  ctl_t              next_st;
  logic              handled;
  logic              next_handled;
  logic              done;
  logic              next_done;
  cfg_t              cfg;
  cfg_t              next_cfg;
  logic              ld;
  logic              next_ld;
  logic [3:0]        n;
  logic [3:0]        next_n;
  logic [RES_W+3:0]  acc;
  logic [RES_W+3:0]  next_acc;
  logic [RES_W-1:0]  first;
  logic [RES_W-1:0]  next_first;
  logic [RES_W-1:0]  ofs;
  logic [RES_W-1:0]  next_ofs;
  logic [RES_W-1:0]  sofs;
  logic [RES_W-1:0]  next_sofs;
  logic [RES_W-1:0]  wt;
  logic [RES_W-1:0]  next_wt;
  logic              dld;
  logic              next_dld;
  logic [31:0]       ctrl;
  logic [IRQ_W-1:0]  istat;
  logic [IRQ_W-1:0]  next_istat;
  logic [IRQ_W-1:0]  imask;
  logic              wr_pend;
  logic [7:0]        wr_addr;
  logic [IRQ_W-1:0]  ev;
  logic              addr_ok;
  logic [RES_W-1:0]  res;
  logic              avg_done;

  assign addr_ok  = hsel && hready && htrans[HTRANS_ACT_BIT];
  assign res      = link.frame_result;
  assign avg_done = (n == 4'(OFS_SAMPLES - 1));

  always_comb begin
    next_vcnt    = !sup_s2 ? 32'h0000_0000 : (vcnt < VSTABLE) ? vcnt + 32'h0000_0001 : vcnt;
    next_st      = st;
    next_handled = link.frame_wake ? handled : 1'b0;
    next_done    = 1'b0;
    next_cfg     = cfg;
    next_ld      = 1'b0;
    next_n       = n;
    next_acc     = acc;
    next_first   = first;
    next_ofs     = ofs;
    next_sofs    = sofs;
    next_wt      = wt;
    next_dld     = 1'b0;
    ev           = '0;
    if (link.frame_wake && !handled) begin
      next_handled   = 1'b1;
      next_done      = 1'b1;
      ev[IRQ_FRAME]  = 1'b1;
      if (!sup_s2) begin
        next_st = C_PWRUP;
      end else if (link.wake_cause[CAUSE_TIMER] && st == C_PWRUP) begin
        if (vcnt >= VSTABLE && ctrl[CTRL_RUN]) begin
          next_st  = C_OFS_MEAS;
          next_n   = 4'h0;
          next_acc = '0;
        end
      end else if (link.wake_cause[CAUSE_MEAS]) begin
        case (st)
          C_OFS_MEAS, C_OFS_SCAN: begin
            if (n == 4'h0) begin
              next_first = res;
            end
            next_acc = acc + (RES_W+4)'(res);
            next_n   = n + 4'h1;
            if (n != 4'h0 && jumped(res, first)) begin
              next_st = C_MEAS;
            end else if (avg_done && st == C_OFS_MEAS) begin
              next_ofs = RES_W'(next_acc / (RES_W+4)'(OFS_SAMPLES));
              next_st  = C_OFS_SCAN;
              next_n   = 4'h0;
              next_acc = '0;
            end else if (avg_done) begin
              next_sofs = RES_W'(next_acc / (RES_W+4)'(OFS_SAMPLES));
              next_st   = C_SCAN;
            end
          end
          C_MEAS: begin
            next_wt  = res - ofs;
            next_dld = 1'b1;
          end
          C_SCAN: begin
            if (jumped(res, sofs)) begin
              next_st      = C_MEAS;
              ev[IRQ_JUMP] = 1'b1;
            end
          end
          default: begin
            next_st = C_PWRUP;
          end
        endcase
      end
      if (next_st != st) begin
        ev[IRQ_MODE] = 1'b1;
        next_ld      = 1'b1;
        next_cfg     = mode_cfg((next_st == C_PWRUP) ? MODE_PWRUP :
                       (next_st == C_SCAN || next_st == C_OFS_SCAN) ? MODE_SCAN : MODE_MEAS);
      end
    end
    // hardware set wins over a write-one-to-clear in the same cycle
    next_istat = istat;
    if (wr_pend && wr_addr == A_IRQ_STAT) begin
      next_istat = istat & ~hwdata[IRQ_W-1:0];
    end
    next_istat = next_istat | ev;
  end

  // controller state persists across wake-ups in these registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sup_s1  <= 1'b0;
      sup_s2  <= 1'b0;
      vcnt    <= 32'h0000_0000;
      st      <= C_PWRUP;
      handled <= 1'b0;
      done    <= 1'b0;
      cfg     <= CFG_PWRUP;
      ld      <= 1'b0;
      n       <= 4'h0;
      acc     <= '0;
      first   <= '0;
      ofs     <= '0;
      sofs    <= '0;
      wt      <= '0;
      dld     <= 1'b0;
      istat   <= '0;
    end else begin
      sup_s1  <= supply_ok;
      sup_s2  <= sup_s1;
      vcnt    <= next_vcnt;
      st      <= next_st;
      handled <= next_handled;
      done    <= next_done;
      cfg     <= next_cfg;
      ld      <= next_ld;
      n       <= next_n;
      acc     <= next_acc;
      first   <= next_first;
      ofs     <= next_ofs;
      sofs    <= next_sofs;
      wt      <= next_wt;
      dld     <= next_dld;
      istat   <= next_istat;
    end
  end

  // ==========================================================
  // AHB-Lite slave, zero wait states
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hrdata  <= 32'h0000_0000;
      ctrl    <= 32'h0000_0000;
      imask   <= '0;
    end else begin
      wr_pend <= addr_ok && hwrite;
      wr_addr <= haddr[7:0];
      if (wr_pend && wr_addr == A_CTRL) begin
        ctrl <= hwdata & (32'h0000_0001 << CTRL_RUN);
      end
      if (wr_pend && wr_addr == A_IRQ_MASK) begin
        imask <= hwdata[IRQ_W-1:0];
      end
      if (addr_ok && !hwrite) begin
        case (haddr[7:0])
          A_CTRL:     hrdata <= ctrl;
          A_STATUS:   hrdata <= {24'h00_0000, 3'h0, vcnt >= VSTABLE, 1'b0, 3'(st)};
          A_WEIGHT:   hrdata <= 32'(wt);
          A_OFFSET:   hrdata <= 32'(ofs);
          A_IRQ_STAT: hrdata <= 32'(istat);
          A_IRQ_MASK: hrdata <= 32'(imask);
          default:    hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign hreadyout       = 1'b1;
  assign hresp           = HRESP_OKAY;
  assign irq             = |(istat & imask);
  assign weight          = wt;
  assign link.cfg        = cfg;
  assign link.cfg_load   = ld;
  assign link.prog_done  = done;
  assign link.disp_value = wt;
  assign link.disp_load  = dld;
endmodule

// ==== tb/strain_link_props.sv ====
// link checker between the frame sequencer and the mode controller
`timescale 1ns/100ps
module strain_link_props (
  input wire logic                               hclk,
  input wire logic                               hresetn,
  input wire strain_seq_pkg::cfg_t               cfg,
  input wire logic                               cfg_load,
  input wire logic                               prog_done,
  input wire logic [strain_seq_pkg::RES_W-1:0]   disp_value,
  input wire logic                               disp_load,
  input wire logic                               brief_wake,
  input wire logic                               frame_wake,
  input wire logic [strain_seq_pkg::CAUSE_W-1:0] wake_cause,
  input wire logic [strain_seq_pkg::RES_W-1:0]   frame_result
);
  import strain_seq_pkg::*;
  // ==========================================================
  // brief wakes since the last frame end, one per conversion
  logic       brief_q;
  logic [7:0] brief_cnt;
  logic [7:0] next_brief_cnt;
  always_comb begin
    next_brief_cnt = brief_cnt;
    if (frame_wake)
      next_brief_cnt = 8'h00;
    else if (brief_wake && !brief_q)
      next_brief_cnt = brief_cnt + 8'h01;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      brief_cnt <= 8'h00;
      brief_q   <= 1'b0;
    end else begin
      brief_cnt <= next_brief_cnt;
      brief_q   <= brief_wake;
    end
  end
  // ==========================================================
  // properties
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  AST_DONE_IN_WAKE: assert property (prog_done |-> frame_wake) else $error("done outside frame end");
  AST_WAKE_RELEASE: assert property (prog_done |=> !frame_wake) else $error("frame wake held");
  AST_WAKE_ANSWER: assert property ($rose(frame_wake) |-> ##[1:3] prog_done) else $error("no done");
  AST_BRIEF_WIDTH: assert property ($rose(brief_wake) |-> brief_wake[*8] ##1 brief_wake[*8] ##1 !brief_wake)
    else $error("brief wake width");
  AST_QUIET_END: assert property (frame_wake |-> !brief_wake) else $error("brief in frame end");
  AST_ONE_CAUSE: assert property (frame_wake |-> $onehot(wake_cause)) else $error("wake cause");
  AST_HOLD_RESULT: assert property (frame_wake && $past(frame_wake) |-> $stable(wake_cause) && $stable(frame_result))
    else $error("frame result moved");
  // measuring 1+16 conversions, scan 1+4, sleeping frames none
  AST_CONV_COUNT: assert property ($rose(frame_wake) |-> (wake_cause[1] ? brief_cnt == 8'h00 :
    (brief_cnt == 8'h11 || brief_cnt == 8'h05))) else $error("conversion count");
  AST_CFG_WITH_DONE: assert property (cfg_load |-> prog_done) else $error("config outside frame end");
  AST_CFG_TABLE: assert property (cfg_load |-> (cfg == CFG_PWRUP || cfg == CFG_MEAS || cfg == CFG_SCAN))
    else $error("unknown config");
  cover property (disp_load && disp_value != '0);
endmodule

// ==== tb/tb_strain_frame_mode_sequencer.sv ====
// self-checking bench joining the frame sequencer to the mode controller
`timescale 1ns/100ps
module tb_strain_frame_mode_sequencer;
  import strain_seq_pkg::*;
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
  } row_t;
  localparam logic [31:0] BASE = 32'h0000_0100;
  logic        hclk, hresetn, supply_ok, hsel, hwrite, hreadyout, hresp, irq, seen;
  logic        conv_active, comparator_on, osc_on, display_on, gain_temp_en, cpu_awake;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, weight, display_data, disch_time, r;
  int          mismatches, comparisons;
  row_t        rows [5];
  strain_link_if link ();
  strain_frame_sequencer #(.FRAME_TICK(4), .CYC_UNIT(1), .BRIEF_CYC(BRIEF_WAKE_CYC)) strain_frame_sequencer_i (
    .hclk(hclk), .hresetn(hresetn), .link(link), .disch_time(disch_time), .conv_active(conv_active),
    .comparator_on(comparator_on), .osc_on(osc_on), .display_on(display_on), .gain_temp_en(gain_temp_en),
    .cpu_awake(cpu_awake), .display_data(display_data));
  strain_mode_controller #(.VSTABLE(20), .JUMP(LOAD_JUMP_CNT)) strain_mode_controller_i (
    .hclk(hclk), .hresetn(hresetn), .link(link), .supply_ok(supply_ok), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .weight(weight));
  strain_link_props strain_link_props_i (
    .hclk(hclk), .hresetn(hresetn), .cfg(link.cfg), .cfg_load(link.cfg_load), .prog_done(link.prog_done),
    .disp_value(link.disp_value), .disp_load(link.disp_load), .brief_wake(link.brief_wake),
    .frame_wake(link.frame_wake), .wake_cause(link.wake_cause), .frame_result(link.frame_result));
  // ==========================================================
  // tasks
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic timeout();
    mismatches++;
    $display("wait limit hit at %0t", $time);
    end_of_test();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdy();
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 16);
    if (hreadyout !== 1'b1)
      timeout();
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h00_0000, a};
    rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    q = hrdata;
  endtask
  task automatic wait_frames(input int n);
    logic q;
    int   k;
    q = link.frame_wake;
    for (k = 0; k < 40000 && n > 0; k++) begin
      @(posedge hclk);
      if (link.frame_wake === 1'b1 && q !== 1'b1)
        n--;
      q = link.frame_wake;
    end
    if (n > 0)
      timeout();
  endtask
  // polls the controller state; notes whether scan offset was passed through
  task automatic wait_state(input logic [2:0] s);
    int k;
    seen = 1'b0;
    for (k = 0; k < 20000; k++) begin
      bus(1'b0, A_STATUS, 32'h0000_0000, r);
      if (r[2:0] === 3'h3)
        seen = 1'b1;
      if (r[2:0] === s)
        return;
    end
    timeout();
  endtask
  task automatic rst();
    hresetn <= 1'b0;
    supply_ok <= 1'b0;
    disch_time <= BASE;
    repeat (6) @(posedge hclk);
    chk(weight | display_data, 32'h0000_0000);
    chk({28'h0, irq, display_on, link.frame_wake, link.brief_wake}, 32'h0000_0000);
    hresetn <= 1'b1;
    $display("reset test done");
  endtask
  // ==========================================================
  // stimulus
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  initial begin
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'h0;
    hsize = 3'h2;
    haddr = 32'h0000_0000;
    hwdata = 32'h0000_0000;
    mismatches = 0;
    comparisons = 0;
    rows = '{'{A_CTRL, 32'h0000_0001, 32'h0000_0001}, '{A_IRQ_MASK, 32'h0000_0007, 32'h0000_0007},
      '{A_STATUS, 32'hFFFF_FFFF, 32'h0000_0000}, '{A_WEIGHT, 32'h0000_1234, 32'h0000_0000},
      '{8'h20, 32'h0000_5555, 32'h0000_0000}};
    rst();
    foreach (rows[i]) begin
      bus(1'b1, rows[i].addr, rows[i].wdata, r);
      bus(1'b0, rows[i].addr, 32'h0000_0000, r);
      chk(r, rows[i].rdata);
    end
    wait_frames(1);
    chk({30'h0, link.wake_cause}, 32'h0000_0002);
    chk({28'h0, conv_active, comparator_on, osc_on, display_on}, 32'h0000_0000);
    $display("power-up test done");
    supply_ok <= 1'b1;
    wait_state(3'h1);
    wait_frames(2);
    disch_time <= BASE + 32'h0000_0005;
    wait_state(3'h2);
    chk({31'h0, seen}, 32'h0000_0000);
    $display("offset abort test done");
    rst();
    supply_ok <= 1'b1;
    bus(1'b1, A_CTRL, 32'h0000_0001, r);
    bus(1'b1, A_IRQ_MASK, 32'h0000_0007, r);
    wait_state(3'h4);
    chk({30'h0, seen, display_on}, 32'h0000_0002);
    disch_time <= BASE + 32'h0000_000A;
    wait_state(3'h2);
    wait_frames(2);
    chk(weight, 32'h0000_00A0);
    chk(display_data, 32'h0000_00A0);
    chk({30'h0, display_on, irq}, 32'h0000_0003);
    chk({28'h0, cpu_awake, gain_temp_en, hresp, link.wake_cause[0]}, 32'h0000_000D);
    // the next measuring frame is well inside its first conversion by then
    repeat (8) @(posedge hclk);
    chk({29'h0, conv_active, comparator_on, osc_on}, 32'h0000_0007);
    bus(1'b1, A_IRQ_MASK, 32'h0000_0000, r);
    bus(1'b0, A_IRQ_STAT, 32'h0000_0000, r);
    chk({29'h0, r[2], 1'b0, irq}, 32'h0000_0004);
    bus(1'b1, A_IRQ_STAT, 32'h0000_0004, r);
    bus(1'b1, A_IRQ_MASK, 32'h0000_0001, r);
    bus(1'b0, A_IRQ_STAT, 32'h0000_0000, r);
    chk({29'h0, r[2], 1'b0, irq}, 32'h0000_0001);
    $display("scan jump test done");
    end_of_test();
  end
endmodule
